// [core/xsc_clk_gate.sv]
// module: half-rate clock output that can be frozen high
// assumes: stop is a level from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module xsc_clk_gate (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic stop,
  output logic      clk_out
);
  // freezes only once high, so no phase is ever cut short
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_out <= 1'b0;
    end else if (ce) begin
      if (!stop || !clk_out) begin
        clk_out <= ~clk_out;
      end
    end
  end
endmodule
`default_nettype wire

// [core/xsc_flag.sv]
// module: sticky indicator flag, set by hardware, cleared by software
// assumes: set and clear arrive from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module xsc_flag (
  input  wire logic   clk,
  input  wire logic   rst_b,
  input  wire logic   ce,
  xsc_flag_if.owner   f
);
  logic flag_q;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (f.set) begin
        flag_q <= 1'b1;
      end else if (f.clr) begin
        flag_q <= 1'b0;
      end
    end
  end

  assign f.flag = flag_q;
endmodule
`default_nettype wire

// [core/xsc_flag_if.sv]
// interface: set, clear and state of one sticky indicator flag
// assumes: set and clear are single-cycle pulses on the core clock
`timescale 1ns/1ns
`default_nettype none
interface xsc_flag_if;
  logic set;
  logic clr;
  logic flag;
  modport owner (input set, input clr, output flag);
  modport user  (output set, output clr, input flag);
endinterface
`default_nettype wire

// [core/xsc_pkg.sv]
// package: field layout, decode codes, reset value and timing of the
// transceiver state and control register
// assumes: a single 100 MHz core clock drives every user of it
package xsc_pkg;
  localparam int unsigned DATA_W        = 16;
  localparam logic [1:0]  BANK_SEL      = 2'h3;
  localparam logic [2:0]  SLOT_SEL      = 3'h2;
  localparam logic [15:0] RESET_VAL     = 16'h0000;
  localparam int unsigned B_FAST_SYNTH  = 15;
  localparam int unsigned B_CODEC_FRZ   = 14;
  localparam int unsigned B_VP_STOP     = 13;
  localparam int unsigned B_GAIN_SEL    = 12;
  localparam int unsigned B_BIAS_EN     = 11;
  localparam int unsigned B_TX_EN       = 10;
  localparam int unsigned B_ALT_PATTERN = 9;
  localparam int unsigned B_MODE_HI     = 8;
  localparam int unsigned B_MODE_LO     = 7;
  localparam int unsigned B_HOP_EN      = 6;
  localparam int unsigned B_SYNC_CLR    = 5;
  localparam int unsigned B_FRAME_CLR   = 4;
  localparam int unsigned B_SLEEP_ARM   = 3;
  localparam int unsigned B_MUX_HI      = 2;
  localparam int unsigned B_MUX_LO      = 1;
  localparam int unsigned B_SLEEP_CMD   = 0;
  localparam logic [1:0]  MODE_WINDOW   = 2'h1;
  localparam logic [1:0]  MODE_FULL     = 2'h2;
  localparam logic [1:0]  MUX_INVERT    = 2'h1;
  localparam logic [1:0]  MUX_FULL      = 2'h3;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned WAKE_MIN_MS   = 10;
  localparam int unsigned WAKE_HOLD_CYC = WAKE_MIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned WAKE_CNT_W    = 20;
  typedef enum logic [1:0] {
    XSC_AWAKE,
    XSC_ASLEEP,
    XSC_WOKEN
  } xsc_sleep_t;
endpackage

// [core/xsc_top.sv]
// top: transceiver state and control register with its side effects
// assumes: core bus and event inputs share clk; wake_pin_in is async
`timescale 1ns/1ns
`default_nettype none

module xsc_top #(
  parameter int unsigned WAKE_HOLD_CYCLES = xsc_pkg::WAKE_HOLD_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      ce,
  input  wire logic [1:0]                ext_bank,
  input  wire logic [2:0]                ext_addr,
  input  wire logic                      ext_wr,
  input  wire logic                      ext_rd,
  input  wire logic [xsc_pkg::DATA_W-1:0] ext_wdata,
  output logic [xsc_pkg::DATA_W-1:0]      ext_rdata,
  input  wire logic                      wake_pin_in,
  input  wire logic                      sleep_timer_done,
  input  wire logic                      frame_start,
  input  wire logic                      sync_detected,
  input  wire logic                      bias_window,
  input  wire logic                      pa_on_timing,
  input  wire logic                      mod_power_timing,
  input  wire logic                      hop_pulse_in,
  output logic                           fast_synth_after_sleep,
  output logic                           codec_clock_out,
  output logic                           voice_proc_clock_out,
  output logic                           bit_sync_gain_select,
  output logic                           bias_update_enable,
  output logic                           tx_enable,
  output logic                           power_amp_on_pin,
  output logic                           modulator_power_on,
  output logic                           sync_alt_pattern,
  output logic                           search_window_en,
  output logic                           search_full_en,
  output logic                           hop_pulse_pin,
  output logic                           sync_found_flag,
  output logic                           new_frame_flag,
  output logic                           sleep_mode,
  output logic                           bit_inversion_en,
  output logic                           voice_proc_access_en
);
  import xsc_pkg::*;

  logic [DATA_W-1:0]     ctrl_q;
  logic                  hit;
  logic                  wr_hit;
  logic                  sync_clr_edge;
  logic                  frame_clr_edge;
  logic                  sleep_cmd_edge;
  logic                  bias_applied_q;
  logic                  wake_s1_q;
  logic                  wake_s2_q;
  logic                  wake_s3_q;
  logic                  wake_q;
  xsc_sleep_t            state_q;
  logic [WAKE_CNT_W-1:0] hold_cnt_q;
  logic                  hold_done;
  logic [1:0]            mode;
  logic [1:0]            mux;

  xsc_flag_if sync_if ();
  xsc_flag_if frame_if ();

  // the register answers only in bank 3, slot two
  assign hit    = (ext_bank == BANK_SEL) && (ext_addr == SLOT_SEL);
  assign wr_hit = hit && ext_wr;

  // edges seen against the stored copy within the write cycle
  assign sync_clr_edge  = wr_hit && ctrl_q[B_SYNC_CLR]
                          && !ext_wdata[B_SYNC_CLR];
  assign frame_clr_edge = wr_hit && ctrl_q[B_FRAME_CLR]
                          && !ext_wdata[B_FRAME_CLR];
  assign sleep_cmd_edge = wr_hit && !ctrl_q[B_SLEEP_CMD]
                          && ext_wdata[B_SLEEP_CMD];

  assign mode = ctrl_q[B_MODE_HI:B_MODE_LO];
  assign mux  = ctrl_q[B_MUX_HI:B_MUX_LO];

  // register storage; every bit reads back what was written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= RESET_VAL;
    end else if (ce && wr_hit) begin
      ctrl_q <= ext_wdata;
    end
  end

  // registered read port; other slots read as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_rdata <= '0;
    end else if (ce) begin
      if (ext_rd && hit) begin
        ext_rdata <= ctrl_q;
      end else begin
        ext_rdata <= '0;
      end
    end
  end

  // a clear fires only on a 1 to 0 write, so the bit must be set again
  assign sync_if.set  = sync_detected;
  assign sync_if.clr  = sync_clr_edge;
  assign frame_if.set = frame_start;
  assign frame_if.clr = frame_clr_edge;

  xsc_flag u_sync_flag (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .f     (sync_if)
  );

  xsc_flag u_frame_flag (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .f     (frame_if)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_found_flag <= 1'b0;
    end else if (ce) begin
      sync_found_flag <= sync_if.flag;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      new_frame_flag <= 1'b0;
    end else if (ce) begin
      new_frame_flag <= frame_if.flag;
    end
  end

  // codec clock freezes only while asleep and only if asked
  xsc_clk_gate u_codec_clk (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .stop    (ctrl_q[B_CODEC_FRZ] && sleep_mode),
    .clk_out (codec_clock_out)
  );

  xsc_clk_gate u_voice_clk (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .stop    (ctrl_q[B_VP_STOP]),
    .clk_out (voice_proc_clock_out)
  );

  // synth acceleration and loop gain take effect at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_synth_after_sleep <= 1'b0;
    end else if (ce) begin
      fast_synth_after_sleep <= ctrl_q[B_FAST_SYNTH];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_sync_gain_select <= 1'b0;
    end else if (ce) begin
      bit_sync_gain_select <= ctrl_q[B_GAIN_SEL];
    end
  end

  // bias enable is sampled only at frame start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bias_applied_q <= 1'b0;
    end else if (ce && frame_start) begin
      bias_applied_q <= ctrl_q[B_BIAS_EN];
    end
  end

  // the held estimate stays valid outside; only updates stop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bias_update_enable <= 1'b0;
    end else if (ce) begin
      bias_update_enable <= bias_applied_q && bias_window;
    end
  end

  // transmit gating of the amplifier pin and modulator power
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_enable <= 1'b0;
    end else if (ce) begin
      tx_enable <= ctrl_q[B_TX_EN];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_amp_on_pin   <= 1'b0;
      modulator_power_on <= 1'b0;
    end else if (ce) begin
      power_amp_on_pin   <= ctrl_q[B_TX_EN] && pa_on_timing;
      modulator_power_on <= ctrl_q[B_TX_EN] && mod_power_timing;
    end
  end

  // search controls; code 11 searches nothing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_alt_pattern <= 1'b0;
    end else if (ce) begin
      sync_alt_pattern <= ctrl_q[B_ALT_PATTERN];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      search_window_en <= 1'b0;
      search_full_en   <= 1'b0;
    end else if (ce) begin
      search_window_en <= (mode == MODE_WINDOW);
      search_full_en   <= (mode == MODE_FULL);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hop_pulse_pin <= 1'b0;
    end else if (ce) begin
      hop_pulse_pin <= ctrl_q[B_HOP_EN] && hop_pulse_in;
    end
  end

  // reserved mux code 10 behaves as plain mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_inversion_en     <= 1'b0;
      voice_proc_access_en <= 1'b0;
    end else if (ce) begin
      bit_inversion_en     <= (mux == MUX_INVERT) || (mux == MUX_FULL);
      voice_proc_access_en <= (mux == MUX_FULL);
    end
  end

  // wake pin synchroniser; level changes once stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wake_s3_q <= 1'b0;
      wake_q    <= 1'b0;
    end else if (ce) begin
      wake_s1_q <= wake_pin_in;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
      if (wake_s2_q == wake_s3_q) begin
        wake_q <= wake_s3_q;
      end
    end
  end

  // a wake event is held this long so software can disarm in time
  assign hold_done = (hold_cnt_q == WAKE_CNT_W'(WAKE_HOLD_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt_q <= '0;
    end else if (ce) begin
      if (state_q != XSC_WOKEN) begin
        hold_cnt_q <= '0;
      end else if (!hold_done) begin
        hold_cnt_q <= hold_cnt_q + 1'b1;
      end
    end
  end

  // sleep sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= XSC_AWAKE;
    end else if (ce) begin
      case (state_q)
        XSC_AWAKE: begin
          if (sleep_cmd_edge && ctrl_q[B_SLEEP_ARM]) begin
            state_q <= XSC_ASLEEP;
          end
        end
        XSC_ASLEEP: begin
          if (sleep_timer_done) begin
            state_q <= XSC_AWAKE;
          end else if (wake_q) begin
            state_q <= XSC_WOKEN;
          end
        end
        XSC_WOKEN: begin
          // still armed when the pin drops: back to sleep
          if (hold_done && !wake_q) begin
            if (ctrl_q[B_SLEEP_ARM]) begin
              state_q <= XSC_ASLEEP;
            end else begin
              state_q <= XSC_AWAKE;
            end
          end
        end
        default: begin
          state_q <= XSC_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_mode <= 1'b0;
    end else if (ce) begin
      sleep_mode <= (state_q == XSC_ASLEEP);
    end
  end
endmodule
`default_nettype wire

// [verif/xsc_assertions.sv]
// checker: timing relations at the register block's ports
// assumes: bound to the top module; one clock, async active low reset
`timescale 1ns/1ns
`default_nettype none
module xsc_assertions (
  input wire logic                       clk,
  input wire logic                       rst_b,
  input wire logic                       ce,
  input wire logic [1:0]                 ext_bank,
  input wire logic [2:0]                 ext_addr,
  input wire logic                       ext_wr,
  input wire logic                       ext_rd,
  input wire logic [xsc_pkg::DATA_W-1:0] ext_wdata,
  input wire logic [xsc_pkg::DATA_W-1:0] ext_rdata,
  input wire logic                       sync_detected,
  input wire logic                       bias_window,
  input wire logic                       pa_on_timing,
  input wire logic                       hop_pulse_in,
  input wire logic                       voice_proc_clock_out,
  input wire logic                       bias_update_enable,
  input wire logic                       tx_enable,
  input wire logic                       power_amp_on_pin,
  input wire logic                       search_window_en,
  input wire logic                       search_full_en,
  input wire logic                       hop_pulse_pin,
  input wire logic                       sync_found_flag,
  input wire logic                       new_frame_flag,
  input wire logic                       bit_inversion_en,
  input wire logic                       voice_proc_access_en
);
  import xsc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic sel;
  assign sel = ce && ext_bank == BANK_SEL && ext_addr == SLOT_SEL;
  logic [1:0] mux_w;
  logic [1:0] mode_w;
  assign mux_w  = ext_wdata[B_MUX_HI:B_MUX_LO];
  assign mode_w = ext_wdata[B_MODE_HI:B_MODE_LO];
  sequence s_stop;
    ext_wr && sel && ext_wdata[B_VP_STOP];
  endsequence
  sequence s_high3;
    voice_proc_clock_out [*3];
  endsequence
  a_write_tx_en: assert property (
    ext_wr && sel |-> ##2 tx_enable == $past(ext_wdata[B_TX_EN], 2)) else $error("tx enable");
  a_rdata_idle: assert property (
    ce && !(ext_rd && sel) |=> ext_rdata == 16'h0000) else $error("read data idle");
  a_pa_gate: assert property (
    power_amp_on_pin == (tx_enable && $past(pa_on_timing))) else $error("pa gate");
  a_hop_gate: assert property (
    hop_pulse_pin |-> $past(hop_pulse_in)) else $error("hop gate");
  a_vp_stop: assert property (s_stop |-> ##3 s_high3) else $error("vp stop");
  a_sync_set: assert property (
    $rose(sync_found_flag) |-> $past(sync_detected) || $past(sync_detected, 2))
    else $error("sync set");
  a_frame_clear: assert property (
    $fell(new_frame_flag) |-> $past(ext_wr, 2) || $past(ext_wr, 3)) else $error("frame clr");
  a_mux_decode: assert property (
    ext_wr && sel |-> ##2 (voice_proc_access_en == ($past(mux_w, 2) == MUX_FULL))
      && (bit_inversion_en == (($past(mux_w, 2) == MUX_INVERT) || ($past(mux_w, 2) == MUX_FULL))))
    else $error("mux decode");
  a_search_mode: assert property (
    ext_wr && sel |-> ##2 (search_full_en == ($past(mode_w, 2) == MODE_FULL))
      && (search_window_en == ($past(mode_w, 2) == MODE_WINDOW)))
    else $error("search mode");
  a_bias_window: assert property (
    bias_update_enable |-> $past(bias_window)) else $error("bias window");
endmodule
bind xsc_top xsc_assertions chk_u (.*);
`default_nettype wire

// [verif/xsc_core_model.sv]
// partner: core side register master, bank select and slot write/read
// assumes: design samples on rising clk; bus changes at falling edges
`timescale 1ns/1ns
`default_nettype none
module xsc_core_model (
  input  wire logic                       clk,
  input  wire logic [xsc_pkg::DATA_W-1:0] ext_rdata,
  output logic [1:0]                      ext_bank,
  output logic [2:0]                      ext_addr,
  output logic                            ext_wr,
  output logic                            ext_rd,
  output logic [xsc_pkg::DATA_W-1:0]      ext_wdata
);
  import xsc_pkg::*;
  initial begin
    ext_bank = BANK_SEL;
    ext_addr = SLOT_SEL;
    ext_wr = 1'b0;
    ext_rd = 1'b0;
    ext_wdata = 16'h0000;
  end
  task automatic wr(input logic [1:0] b, input logic [2:0] a, input logic [15:0] d);
    @(negedge clk);
    ext_bank = b;
    ext_addr = a;
    ext_wdata = d;
    ext_wr = 1'b1;
    @(negedge clk);
    ext_wr = 1'b0;
    // released data shows no stale word
    ext_wdata = ~d;
  endtask
  task automatic rd(output logic [15:0] d);
    @(negedge clk);
    ext_bank = BANK_SEL;
    ext_addr = SLOT_SEL;
    ext_rd = 1'b1;
    @(negedge clk);
    d = ext_rdata;
    ext_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/xsc_top_tb.sv]
// testbench: scenario tasks for the state and control register
// assumes: core model drives the bus; events driven at falling edges
`timescale 1ns/1ns
`default_nettype none
module xsc_top_tb;
  import xsc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, wk = 1'b0, tdone = 1'b0, fs = 1'b0, sd = 1'b0;
  logic bw = 1'b0, pat = 1'b0, mpt = 1'b0, hpi = 1'b0, ce = 1'b1;
  logic [1:0] bank;
  logic [2:0] addr;
  logic wr, rd, fast, cod, vpc, gain, bue, txe, pa, mp, alt, swin, sfull, hop, sfl, nfl, slp, inv, acc;
  logic [15:0] wd, rdat, v;
  int miscompares = 0, checked = 0, cyc = 0;
  xsc_top #(.WAKE_HOLD_CYCLES(8)) dut_u (.clk(clk), .rst_b(rst_b), .ce(ce),
    .ext_bank(bank), .ext_addr(addr), .ext_wr(wr), .ext_rd(rd), .ext_wdata(wd),
    .ext_rdata(rdat), .wake_pin_in(wk), .sleep_timer_done(tdone), .frame_start(fs),
    .sync_detected(sd), .bias_window(bw), .pa_on_timing(pat), .mod_power_timing(mpt),
    .hop_pulse_in(hpi), .fast_synth_after_sleep(fast), .codec_clock_out(cod),
    .voice_proc_clock_out(vpc), .bit_sync_gain_select(gain), .bias_update_enable(bue),
    .tx_enable(txe), .power_amp_on_pin(pa), .modulator_power_on(mp),
    .sync_alt_pattern(alt), .search_window_en(swin), .search_full_en(sfull),
    .hop_pulse_pin(hop), .sync_found_flag(sfl), .new_frame_flag(nfl), .sleep_mode(slp),
    .bit_inversion_en(inv), .voice_proc_access_en(acc));
  xsc_core_model core_u (.clk(clk), .ext_rdata(rdat), .ext_bank(bank), .ext_addr(addr),
    .ext_wr(wr), .ext_rd(rd), .ext_wdata(wd));
  initial forever #5 clk = ~clk;
  task automatic close_out;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic w(input logic [15:0] d);
    core_u.wr(BANK_SEL, SLOT_SEL, d);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic t_reset;
    core_u.rd(v);
    chk("reset", RESET_VAL, v);
    chk("outs", 16'h0000, {fast, gain, txe, sfl, nfl, slp, inv, acc});
  endtask
  task automatic t_fields;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      d = 16'h0000;
      {d[B_FAST_SYNTH], d[B_GAIN_SEL], d[B_TX_EN], d[B_ALT_PATTERN]} = {4{i[0]}};
      d[B_MODE_HI:B_MODE_LO] = i[1:0];
      d[B_MUX_HI:B_MUX_LO] = i[1:0];
      w(d);
      wt(2);
      core_u.rd(v);
      chk("readback", d, v);
      chk("decode", {8'h00, {4{i[0]}}, i == 1, i == 2, i[0], i == 3},
          {8'h00, fast, gain, txe, alt, swin, sfull, inv, acc});
    end
  endtask
  task automatic t_refuse;
    core_u.wr(2'h2, SLOT_SEL, 16'h0400);
    core_u.wr(BANK_SEL, 3'h3, 16'h0400);
    wt(2);
    core_u.rd(v);
    // register keeps the last field write untouched
    chk("refused", 16'h9786, v);
  endtask
  task automatic t_tx_hop;
    {pat, mpt, hpi} = 3'b111;
    w(16'h0440);
    wt(3);
    chk("gated on", 16'h0007, {pa, mp, hop});
    w(16'h0000);
    wt(3);
    chk("gated off", 16'h0000, {pa, mp, hop});
  endtask
  task automatic t_bias;
    bw = 1'b1;
    w(16'h0800);
    wt(3);
    chk("bias early", 16'h0000, bue);
    pulse(fs);
    wt(3);
    chk("bias frame", 16'h0001, bue);
    bw = 1'b0;
    wt(2);
    chk("bias window", 16'h0000, bue);
  endtask
  task automatic t_flags;
    pulse(sd);
    pulse(fs);
    wt(3);
    chk("flags set", 16'h0003, {sfl, nfl});
    w(16'h0030);
    w(16'h0010);
    wt(3);
    chk("sync clr", 16'h0001, {sfl, nfl});
    core_u.rd(v);
    chk("clr readback", 16'h0010, v);
    w(16'h0000);
    wt(3);
    chk("frame clr", 16'h0000, {sfl, nfl});
    w(16'h0010);
    // clear and frame start meet at one edge: the set wins
    fork
      core_u.wr(BANK_SEL, SLOT_SEL, 16'h0000);
      pulse(fs);
    join
    wt(3);
    chk("set wins", 16'h0001, {sfl, nfl});
    w(16'h0000);
    wt(3);
    chk("no edge", 16'h0001, {sfl, nfl});
  endtask
  task automatic t_vp;
    w(16'h2000);
    wt(3);
    chk("vp stop", 16'h0001, vpc);
    wt(1);
    chk("vp held", 16'h0001, vpc);
    wt(2);
    w(16'h0000);
    wt(3);
    v[0] = vpc;
    wt(1);
    chk("vp runs", {15'h0000, ~v[0]}, vpc);
  endtask
  task automatic t_freeze;
    ce = 1'b0;
    v[0] = vpc;
    w(16'h0400);
    wt(1);
    chk("ce clock", {15'h0000, v[0]}, vpc);
    chk("ce tx", 16'h0000, txe);
    ce = 1'b1;
    core_u.rd(v);
    chk("ce write", 16'h0000, v);
  endtask
  task automatic t_sleep;
    w(16'h0001);
    wt(3);
    chk("no arm", 16'h0000, slp);
    w(16'h0008);
    w(16'h4009);
    wt(3);
    chk("asleep", 16'h0001, slp);
    v[0] = cod;
    wt(1);
    chk("codec frozen", {15'h0000, v[0]}, cod);
    chk("codec high", 16'h0001, cod);
    pulse(tdone);
    wt(3);
    chk("timer wake", 16'h0000, slp);
    w(16'h4008);
    w(16'h4009);
    // pin pulse shorter than the hold, so only the hold keeps it awake
    wk = 1'b1;
    wt(4);
    wk = 1'b0;
    wt(4);
    chk("pin wake", 16'h0000, slp);
    wt(4);
    chk("held woken", 16'h0000, slp);
    wt(4);
    chk("resleep", 16'h0001, slp);
    wk = 1'b1;
    wt(4);
    wk = 1'b0;
    w(16'h4000);
    wt(8);
    chk("disarmed", 16'h0000, slp);
    w(16'h0000);
    wt(3);
    chk("awake", 16'h0000, slp);
  endtask
  initial begin
    wt(20);
    rst_b = 1'b1;
    t_reset();
    t_fields();
    t_refuse();
    t_tx_hop();
    t_bias();
    t_flags();
    t_vp();
    t_freeze();
    t_sleep();
    close_out();
  end
endmodule
`default_nettype wire
